// *** cmd_block_defs.svh ***
`ifndef CMD_BLOCK_DEFS_SVH
`define CMD_BLOCK_DEFS_SVH
// ==========================================
// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_RXMODE 8'h08
`define OFF_MOVE_CNT 8'h0C
`define OFF_MOVE_ADDR 8'h10
`define OFF_MOVE_CTRL 8'h14
`define OFF_MEMCFG0 8'h18
`define OFF_MEMCFG5 8'h2C
`define OFF_BUFINFO 8'h30
`define OFF_RXTMO 8'h34
// ==========================================
// field positions
`define CTRL_DIR_BIT 0
`define ST_ABORT_BIT 8
`define ST_RXTMO_BIT 9
// ==========================================
// flag pair states
`define FLG_NONE 2'b00
`define FLG_ACCEPT 2'b01
`define FLG_REJECT 2'b10
`define FLG_END 2'b11
// ==========================================
// command and response codes, data lengths
`define CMD_MEMCFG 8'h01
`define CMD_RXMODE 8'h02
`define CMD_ADDR 8'h03
`define CMD_DMA_DN 8'h04
`define CMD_DMA_UP 8'h05
`define CMD_PIO_DN 8'h06
`define CMD_PIO_UP 8'h07
`define CMD_RXPKT 8'h08
`define RSP_MEMCFG 8'h31
`define RSP_RXMODE 8'h32
`define RSP_ADDR 8'h33
`define RSP_RXPKT 8'h38
`define DLEN_MEMCFG 8'h0C
`define DLEN_RXMODE 8'h02
`define DLEN_ADDR 8'h00
`define DLEN_MOVE 8'h06
`define DLEN_RXPKT 8'h08
`define DLEN_MAX 8'h3E
`define BLK_MAX 8'h40
// ==========================================
// reset values, fixed buffer info and receive timeout limit
`define MEMCFG_DEF0 16'h000A
`define MEMCFG_DEF1 16'h0014
`define MEMCFG_DEF2 16'h0000
`define MEMCFG_DEF3 16'h0014
`define MEMCFG_DEF4 16'h0014
`define MEMCFG_DEF5 16'h000A
`define BUF_BYTES 16'h0640
`define TX_BUFS 16'h0001
`define RXTMO_MAX 16'h7FFF
// ==========================================
// timing
`define CLK_MHZ 50
`define T_FIRST_MS 20
`define T_BYTE_US 500
`define T_TICK_MS 10
`endif

// *** cmd_block_pkg.sv ***
package cmd_block_pkg;
  typedef struct packed {
    logic dma;
    logic upload;
    logic [15:0] count;
    logic [15:0] offset;
    logic [15:0] segment;
  } move_t;
  typedef struct packed {
    logic [1:0] loopback;
    logic promisc;
    logic multicast;
    logic broadcast;
  } rxmode_t;
  typedef enum logic [1:0] {IN_IDLE, IN_ANSWER} in_state_t;
  typedef enum logic [2:0] {O_IDLE, O_SEND, O_LEN, O_WAIT, O_CLR} out_state_t;
endpackage

// *** command_block_handshake.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cmd_block_defs.svh"
// Summary of operation
// (RL1) inbound bytes go into a 64-byte circular buffer in arrival order
// (RL2) block ends only on a byte written while host flags read 11
// (RL3) host puts total length in final byte; locates block start
// (RL4) device answers 01 accept or 10 reject after host end mark
// (RL5) host answers device blocks with 01 or 10
// (RL6) every data byte is stored, even for rejected blocks; the length byte is not
// (RL7) first inbound byte raises the device processor interrupt
// (RL8) host aborts if first byte not taken within 40 ms
// (RL9) host sends later bytes after empty, 500 us timeout
// (RL10) host sets flags 11 before writing the length byte
// (RL11) host waits 50 ms for accept or reject
// (RL12) device writes first byte, aborts if not emptied in 20 ms
// (RL13) device sets 11, writes length, waits for host 01 or 10
// (RL14) each queue entry holds a block of up to 64 bytes
// (RL15) memory config 01/0C holds six counts, defaults, answers 31H
// (RL16) buffers are 1.6Kb, exactly one transmit buffer
// (RL17) receive mode bits 2..0 select broadcast, multicast, promiscuous
// (RL18) receive mode bits 4..3 select loopback none/internal/external
// (RL19) address query 03/00 answered 33H with prom address
// (RL20) moves need matching direction bit, even count; no response
// (RL21) 04/05 move by DMA, 06/07 by programmed io
// (RL22) receive 08 gives 38H on packet, then DMA upload
// (RL23) receive timeout in 10 ms units, zero none, max 32767
// (RL24) data field at most 62 bytes
// (RL25) flags return to 00 after answer before next transfer
module command_block_handshake #(
  parameter int FIRST_CYC = `T_FIRST_MS * 1000 * `CLK_MHZ,
  parameter int BYTE_CYC = `T_BYTE_US * `CLK_MHZ,
  parameter int TICK_CYC = `T_TICK_MS * 1000 * `CLK_MHZ,
  parameter int BUF_DEPTH = 64
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic host_wr_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic host_rd_i,
  output logic [7:0] host_rdata_o,
  input wire logic [1:0] host_flags_i,
  output logic [1:0] device_flags_o,
  output logic host_side_cmd_empty_o,
  output logic device_side_cmd_full_o,
  output logic device_irq_o,
  input wire logic [47:0] prom_addr_i,
  input wire logic pkt_arrived_i,
  output cmd_block_pkg::move_t move_o,
  output logic move_start_o,
  output logic upload_start_o,
  output cmd_block_pkg::rxmode_t rxmode_o
);
  import cmd_block_pkg::*;

  localparam int AW = $clog2(BUF_DEPTH);

  // ==========================================
  // state
  logic [7:0] buf_q [BUF_DEPTH];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d;
  in_state_t in_q, in_d;
  out_state_t out_q, out_d;
  logic [1:0] in_flag_q, in_flag_d, dflag_q, dflag_d;
  logic blk_q, blk_d, ctrl_dir_q, ctrl_dir_d;
  logic abort_q, abort_d, rxtmo_q, rxtmo_d;
  logic [7:0] resp_q [8];
  logic [7:0] resp_d [8];
  logic [3:0] resp_n_q, resp_n_d, idx_q, idx_d;
  logic resp_v_q, resp_v_d, upl_q, upl_d;
  logic [7:0] out_byte_q, out_byte_d;
  logic out_full_q, out_full_d;
  logic [31:0] tmr_q, tmr_d, tick_q, tick_d;
  logic [15:0] ticks_q, ticks_d, rx_tmo_q, rx_tmo_d;
  logic rx_pend_q, rx_pend_d;
  logic [15:0] memcfg_q [6];
  logic [15:0] memcfg_d [6];
  rxmode_t rxmode_q, rxmode_d;
  move_t move_q, move_d;
  logic move_go_q, move_go_d, upl_go_q, upl_go_d;

  // ==========================================
  // inbound decode
  logic [AW-1:0] start;
  logic [7:0] len, code, dlen;
  logic frame_ok, dir_ok, even_ok, room_ok, accept, end_blk, sw_wr;
  logic [7:0] arg0;

  function automatic logic [7:0] at(input logic [AW-1:0] base, input logic [AW-1:0] k);
    at = buf_q[AW'(base + k)];
  endfunction
  function automatic logic [15:0] wd(input logic [AW-1:0] base, input logic [AW-1:0] k);
    wd = {at(base, AW'(k + AW'(1))), at(base, k)};
  endfunction

  assign end_blk = host_wr_i && (host_flags_i == `FLG_END); // RL2
  assign len = host_wdata_i;
  assign start = AW'(wr_ptr_q - len[AW-1:0]); // RL3
  assign code = at(start, AW'(0));
  assign dlen = at(start, AW'(1));
  assign frame_ok = (len <= `BLK_MAX) && (len >= 8'h02) && (dlen <= `DLEN_MAX) // RL14 RL24
                    && (len == 8'(dlen + 8'h02));
  assign arg0 = at(start, AW'(2));
  assign even_ok = ~arg0[0]; // RL20
  assign dir_ok = ctrl_dir_q == code[0]; // RL20
  assign room_ok = (out_q == O_IDLE) && !resp_v_q;

  always_comb begin
    case (code)
      `CMD_MEMCFG: accept = frame_ok && dlen == `DLEN_MEMCFG && room_ok;
      `CMD_RXMODE: accept = frame_ok && dlen == `DLEN_RXMODE && room_ok;
      `CMD_ADDR: accept = frame_ok && dlen == `DLEN_ADDR && room_ok;
      `CMD_DMA_DN, `CMD_DMA_UP, `CMD_PIO_DN, `CMD_PIO_UP: begin
        accept = frame_ok && dlen == `DLEN_MOVE && even_ok && dir_ok;
      end
      `CMD_RXPKT: accept = frame_ok && dlen == `DLEN_RXPKT && !rx_pend_q;
      default: accept = 1'b0;
    endcase
  end

  assign sw_wr = psel_i && penable_i && pwrite_i;

  // ==========================================
  // next state
  always_comb begin
    wr_ptr_d = wr_ptr_q;
    in_d = in_q;
    in_flag_d = in_flag_q;
    blk_d = blk_q;
    out_d = out_q;
    resp_d = resp_q;
    resp_n_d = resp_n_q;
    resp_v_d = resp_v_q;
    idx_d = idx_q;
    upl_d = upl_q;
    out_byte_d = out_byte_q;
    out_full_d = out_full_q;
    tmr_d = tmr_q;
    tick_d = tick_q;
    ticks_d = ticks_q;
    rx_tmo_d = rx_tmo_q;
    rx_pend_d = rx_pend_q;
    memcfg_d = memcfg_q;
    rxmode_d = rxmode_q;
    move_d = move_q;
    move_go_d = 1'b0;
    upl_go_d = 1'b0;
    ctrl_dir_d = ctrl_dir_q;
    abort_d = abort_q;
    rxtmo_d = rxtmo_q;
    if (sw_wr && paddr_i == `OFF_CTRL) begin
      ctrl_dir_d = pwdata_i[`CTRL_DIR_BIT];
    end
    if (sw_wr && paddr_i == `OFF_STATUS) begin
      if (pwdata_i[`ST_ABORT_BIT]) abort_d = 1'b0;
      if (pwdata_i[`ST_RXTMO_BIT]) rxtmo_d = 1'b0;
    end
    // inbound path: data bytes stored, end byte decoded
    if (host_wr_i && !end_blk) begin
      wr_ptr_d = AW'(wr_ptr_q + AW'(1)); // RL1 RL6
      blk_d = 1'b1; // RL7
    end
    if (end_blk) begin
      blk_d = 1'b0;
      in_d = IN_ANSWER;
      in_flag_d = accept ? `FLG_ACCEPT : `FLG_REJECT; // RL4
      if (accept) begin
        case (code)
          `CMD_MEMCFG: begin
            for (int i = 0; i < 6; i++) memcfg_d[i] = wd(start, AW'(2 + 2 * i)); // RL15
            resp_d[0] = `RSP_MEMCFG; // RL15
            resp_d[1] = 8'h02;
            resp_d[2] = 8'h00;
            resp_d[3] = 8'h00;
            resp_n_d = 4'h4;
            resp_v_d = 1'b1;
          end
          `CMD_RXMODE: begin
            rxmode_d = rxmode_t'(arg0[4:0]); // RL17 RL18
            resp_d[0] = `RSP_RXMODE;
            resp_d[1] = 8'h02;
            resp_d[2] = 8'h00;
            resp_d[3] = 8'h00;
            resp_n_d = 4'h4;
            resp_v_d = 1'b1;
          end
          `CMD_ADDR: begin
            resp_d[0] = `RSP_ADDR; // RL19
            resp_d[1] = 8'h06;
            for (int i = 0; i < 6; i++) resp_d[2 + i] = prom_addr_i[8 * i +: 8];
            resp_n_d = 4'h8;
            resp_v_d = 1'b1;
          end
          `CMD_RXPKT: begin
            rx_pend_d = 1'b1; // RL22
            rx_tmo_d = wd(start, AW'(8)) & `RXTMO_MAX; // RL23
            ticks_d = 16'h0000;
            tick_d = 32'h0;
          end
          default: begin
            move_d.dma = ~code[1]; // RL21
            move_d.upload = code[0];
            move_d.count = wd(start, AW'(2));
            move_d.offset = wd(start, AW'(4));
            move_d.segment = wd(start, AW'(6));
            move_go_d = 1'b1; // RL20
          end
        endcase
      end
    end
    if (in_q == IN_ANSWER && host_flags_i != `FLG_END) begin
      in_d = IN_IDLE; // RL25
      in_flag_d = `FLG_NONE;
    end
    // receive request: tick timer and packet arrival
    if (rx_pend_q) begin
      tick_d = (tick_q == 32'(TICK_CYC - 1)) ? 32'h0 : tick_q + 32'h1;
      if (tick_q == 32'(TICK_CYC - 1)) ticks_d = ticks_q + 16'h1; // RL23
      if (pkt_arrived_i && !resp_v_q && out_q == O_IDLE && !end_blk) begin
        rx_pend_d = 1'b0;
        resp_d[0] = `RSP_RXPKT; // RL22
        resp_d[1] = 8'h02;
        resp_d[2] = 8'h00;
        resp_d[3] = 8'h00;
        resp_n_d = 4'h4;
        resp_v_d = 1'b1;
        upl_d = 1'b1;
      end else if (rx_tmo_q != 16'h0000 && ticks_q == rx_tmo_q) begin
        rx_pend_d = 1'b0;
        rxtmo_d = 1'b1;
      end
    end
    // outbound path
    if (host_rd_i) out_full_d = 1'b0;
    case (out_q)
      O_IDLE: begin
        if (resp_v_q && in_q == IN_IDLE && !blk_q) begin
          out_d = O_SEND;
          idx_d = 4'h0;
        end
      end
      O_SEND: begin
        if (out_full_q && tmr_q == 32'h0) begin
          out_d = O_IDLE; // RL12
          abort_d = 1'b1;
          out_full_d = 1'b0;
          resp_v_d = 1'b0;
          upl_d = 1'b0;
        end else if (!out_full_q && idx_q == resp_n_q) begin
          out_d = O_LEN; // RL13
        end else if (!out_full_q) begin
          out_byte_d = resp_q[idx_q[2:0]];
          out_full_d = 1'b1;
          tmr_d = (idx_q == 4'h0) ? 32'(FIRST_CYC) : 32'(BYTE_CYC); // RL12
          idx_d = idx_q + 4'h1;
        end else begin
          tmr_d = tmr_q - 32'h1;
        end
      end
      O_LEN: begin
        out_byte_d = {4'h0, resp_n_q}; // RL13
        out_full_d = 1'b1;
        tmr_d = 32'(BYTE_CYC);
        out_d = O_WAIT;
      end
      O_WAIT: begin
        if (out_full_q && tmr_q == 32'h0) begin
          out_d = O_IDLE;
          abort_d = 1'b1;
          out_full_d = 1'b0;
          resp_v_d = 1'b0;
          upl_d = 1'b0;
        end else if (out_full_q) begin
          tmr_d = tmr_q - 32'h1;
        end else if (host_flags_i == `FLG_ACCEPT || host_flags_i == `FLG_REJECT) begin
          out_d = O_CLR; // RL13
          resp_v_d = 1'b0;
          upl_go_d = upl_q && host_flags_i == `FLG_ACCEPT; // RL22
          upl_d = 1'b0;
        end
      end
      O_CLR: begin
        if (host_flags_i == `FLG_NONE) out_d = O_IDLE; // RL25
      end
      default: out_d = O_IDLE;
    endcase
    // flag pair: inbound answer overrides outbound marking
    if (in_d == IN_ANSWER) begin
      dflag_d = in_flag_d;
    end else if (out_d == O_LEN || out_d == O_WAIT) begin
      dflag_d = `FLG_END; // RL13
    end else begin
      dflag_d = `FLG_NONE; // RL25
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge core_clk_i) begin
    if (host_wr_i && !end_blk) buf_q[wr_ptr_q] <= host_wdata_i; // RL1 RL6
    if (!resetn_i) begin
      wr_ptr_q <= '0;
      in_q <= IN_IDLE;
      in_flag_q <= `FLG_NONE;
      dflag_q <= `FLG_NONE;
      blk_q <= 1'b0;
      out_q <= O_IDLE;
      for (int i = 0; i < 8; i++) resp_q[i] <= 8'h00;
      resp_n_q <= 4'h0;
      resp_v_q <= 1'b0;
      idx_q <= 4'h0;
      upl_q <= 1'b0;
      out_byte_q <= 8'h00;
      out_full_q <= 1'b0;
      tmr_q <= 32'h0;
      tick_q <= 32'h0;
      ticks_q <= 16'h0000;
      rx_tmo_q <= 16'h0000;
      rx_pend_q <= 1'b0;
      memcfg_q[0] <= `MEMCFG_DEF0; // RL15
      memcfg_q[1] <= `MEMCFG_DEF1;
      memcfg_q[2] <= `MEMCFG_DEF2;
      memcfg_q[3] <= `MEMCFG_DEF3;
      memcfg_q[4] <= `MEMCFG_DEF4;
      memcfg_q[5] <= `MEMCFG_DEF5;
      rxmode_q <= '0; // RL18
      move_q <= '0;
      move_go_q <= 1'b0;
      upl_go_q <= 1'b0;
      ctrl_dir_q <= 1'b0;
      abort_q <= 1'b0;
      rxtmo_q <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      in_q <= in_d;
      in_flag_q <= in_flag_d;
      dflag_q <= dflag_d;
      blk_q <= blk_d;
      out_q <= out_d;
      resp_q <= resp_d;
      resp_n_q <= resp_n_d;
      resp_v_q <= resp_v_d;
      idx_q <= idx_d;
      upl_q <= upl_d;
      out_byte_q <= out_byte_d;
      out_full_q <= out_full_d;
      tmr_q <= tmr_d;
      tick_q <= tick_d;
      ticks_q <= ticks_d;
      rx_tmo_q <= rx_tmo_d;
      rx_pend_q <= rx_pend_d;
      memcfg_q <= memcfg_d;
      rxmode_q <= rxmode_d;
      move_q <= move_d;
      move_go_q <= move_go_d;
      upl_go_q <= upl_go_d;
      ctrl_dir_q <= ctrl_dir_d;
      abort_q <= abort_d;
      rxtmo_q <= rxtmo_d;
    end
  end

  // ==========================================
  // apb read mux and outputs
  always_comb begin
    prdata_o = 32'h0;
    pslverr_o = 1'b0;
    case (paddr_i)
      `OFF_CTRL: prdata_o = {31'h0, ctrl_dir_q};
      `OFF_STATUS: prdata_o = {20'h0, (out_q != O_IDLE), rx_pend_q, rxtmo_q, abort_q,
                               2'b00, out_full_q, 1'b1, dflag_q, host_flags_i};
      `OFF_RXMODE: prdata_o = {27'h0, rxmode_q};
      `OFF_MOVE_CNT: prdata_o = {16'h0, move_q.count};
      `OFF_MOVE_ADDR: prdata_o = {move_q.segment, move_q.offset};
      `OFF_MOVE_CTRL: prdata_o = {30'h0, move_q.dma, move_q.upload};
      `OFF_BUFINFO: prdata_o = {`TX_BUFS, `BUF_BYTES}; // RL16
      `OFF_RXTMO: prdata_o = {16'h0, rx_tmo_q};
      default: begin
        if (paddr_i >= `OFF_MEMCFG0 && paddr_i <= `OFF_MEMCFG5 && paddr_i[1:0] == 2'b00) begin
          prdata_o = {16'h0, memcfg_q[3'((paddr_i - `OFF_MEMCFG0) >> 2)]};
        end else begin
          pslverr_o = psel_i && penable_i;
        end
      end
    endcase
  end

  assign pready_o = 1'b1;
  assign host_rdata_o = out_byte_q;
  assign device_flags_o = dflag_q;
  assign host_side_cmd_empty_o = 1'b1;
  assign device_side_cmd_full_o = out_full_q;
  assign device_irq_o = blk_q; // RL7
  assign move_o = move_q;
  assign move_start_o = move_go_q;
  assign upload_start_o = upl_go_q;
  assign rxmode_o = rxmode_q;
endmodule
`default_nettype wire

// *** command_block_handshake_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module cmd_block_props (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [1:0] host_flags_i,
  input wire logic [1:0] device_flags_o,
  input wire logic host_side_cmd_empty_o,
  input wire logic device_side_cmd_full_o,
  input wire logic device_irq_o,
  input wire logic move_start_o,
  input wire logic upload_start_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========
  // inbound handshake
  answer_given_a: assert property (host_wr_i && host_flags_i == 2'b11 |=> device_flags_o inside {2'b01, 2'b10})
    else $error("no answer after end byte");
  answer_hold_a: assert property (device_flags_o inside {2'b01, 2'b10} && host_flags_i == 2'b11 |=> $stable(device_flags_o))
    else $error("answer changed early");
  answer_clear_a: assert property (device_flags_o inside {2'b01, 2'b10} && host_flags_i != 2'b11 |=> device_flags_o == 2'b00)
    else $error("answer not cleared");
  irq_raise_a: assert property (host_wr_i && host_flags_i != 2'b11 |=> device_irq_o)
    else $error("no irq on data byte");
  irq_drop_a: assert property (host_wr_i && host_flags_i == 2'b11 |=> !device_irq_o)
    else $error("irq kept after end byte");
  always_ready_a: assert property (host_wr_i |-> host_side_cmd_empty_o ##1 host_side_cmd_empty_o)
    else $error("inbound byte not taken");
  // ==========
  // outbound and actions
  read_empty_a: assert property (host_rd_i && device_side_cmd_full_o |=> !device_side_cmd_full_o)
    else $error("full kept after read");
  end_mark_a: assert property ($rose(device_side_cmd_full_o) && device_flags_o == 2'b11 |-> $past(device_flags_o) == 2'b11)
    else $error("end mark late");
  move_ack_a: assert property (move_start_o |-> $past(host_wr_i) && $past(host_flags_i) == 2'b11 && device_flags_o == 2'b01)
    else $error("move without accept");
  upload_ack_a: assert property (upload_start_o |-> $past(host_flags_i) == 2'b01 || $past(host_flags_i, 2) == 2'b01)
    else $error("upload without host accept");
  cover property (host_wr_i && host_flags_i == 2'b11 ##1 device_flags_o == 2'b10);
  cover property (move_start_o);
  cover property (upload_start_o);
endmodule
bind command_block_handshake cmd_block_props u_cmd_block_props (.core_clk_i, .resetn_i, .host_wr_i, .host_rd_i,
  .host_flags_i, .device_flags_o, .host_side_cmd_empty_o, .device_side_cmd_full_o, .device_irq_o, .move_start_o,
  .upload_start_o);
`default_nettype wire

// *** host_bfm.sv ***
`timescale 1ns/10ps
`default_nettype none
module host_bfm (
  input wire logic core_clk_i,
  output logic host_wr_o,
  output logic [7:0] host_wdata_o,
  output logic host_rd_o,
  output logic [1:0] host_flags_o,
  input wire logic [1:0] device_flags_i,
  input wire logic full_i,
  input wire logic empty_i
);
  initial begin
    host_wr_o = 1'b0;
    host_wdata_o = 8'h00;
    host_rd_o = 1'b0;
    host_flags_o = 2'b00;
  end
  task automatic tick(inout int i);
    @(posedge core_clk_i);
    i++;
  endtask
  task automatic send(input logic [7:0] b[$], input logic fin, output logic [1:0] ans);
    int i;
    ans = 2'b00;
    foreach (b[k]) begin
      i = 0;
      while (empty_i !== 1'b1 && i < 200) tick(i);
      host_wr_o <= 1'b1;
      host_wdata_o <= b[k];
      @(posedge core_clk_i);
      host_wr_o <= 1'b0;
      host_wdata_o <= ~b[k];
      @(posedge core_clk_i);
    end
    if (fin) begin
      host_flags_o <= 2'b11;
      @(posedge core_clk_i);
      host_wr_o <= 1'b1;
      host_wdata_o <= 8'(b.size());
      @(posedge core_clk_i);
      host_wr_o <= 1'b0;
      host_wdata_o <= ~8'(b.size());
      i = 0;
      while (!(device_flags_i inside {2'b01, 2'b10}) && i < 200) tick(i);
      ans = device_flags_i;
      host_flags_o <= 2'b00;
      @(posedge core_clk_i);
      @(posedge core_clk_i);
    end
  endtask
  task automatic recv(input logic [1:0] ans);
    int i;
    int n;
    logic last;
    last = 1'b0;
    n = 0;
    while (!last && n < 80) begin
      i = 0;
      while (full_i !== 1'b1 && i < 200) tick(i);
      last = (device_flags_i == 2'b11);
      host_rd_o <= 1'b1;
      @(posedge core_clk_i);
      host_rd_o <= 1'b0;
      tick(n);
    end
    host_flags_o <= ans;
    i = 0;
    while (device_flags_i !== 2'b00 && i < 200) tick(i);
    host_flags_o <= 2'b00;
    @(posedge core_clk_i);
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
  import cmd_block_pkg::*;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, host_wr, host_rd, full, empty, irq, pkt, mstart, ustart;
  logic [7:0] paddr, wdata, rdata, tb8;
  logic [31:0] pwdata, prdata;
  logic [1:0] hflags, dflags;
  logic [47:0] prom;
  move_t mv, tmv;
  rxmode_t rxm;
  int err_total, compares, upl_cnt;
  logic [15:0] lf = 16'h0006;
  logic [15:0] mdef[6] = '{16'h000A, 16'h0014, 16'h0000, 16'h0014, 16'h0014, 16'h000A};
  logic [4:0] modes[7] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h03, 5'h08, 5'h10};
  logic [7:0] bq[$];
  move_t mq[$];
  command_block_handshake #(.FIRST_CYC(20), .BYTE_CYC(10), .TICK_CYC(10)) u_command_block_handshake (
    .core_clk_i(clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .host_wr_i(host_wr), .host_wdata_i(wdata), .host_rd_i(host_rd), .host_rdata_o(rdata),
    .host_flags_i(hflags), .device_flags_o(dflags), .host_side_cmd_empty_o(empty),
    .device_side_cmd_full_o(full), .device_irq_o(irq), .prom_addr_i(prom), .pkt_arrived_i(pkt),
    .move_o(mv), .move_start_o(mstart), .upload_start_o(ustart), .rxmode_o(rxm));
  host_bfm u_host_bfm (.core_clk_i(clk), .host_wr_o(host_wr), .host_wdata_o(wdata), .host_rd_o(host_rd),
    .host_flags_o(hflags), .device_flags_i(dflags), .full_i(full), .empty_i(empty));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  task summarize();
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task blk(input logic [7:0] b[$], input logic [1:0] exp_ans);
    logic [1:0] a;
    u_host_bfm.send(b, 1'b1, a);
    `CHK(a, exp_ans)
  endtask
  task rsp(input logic [7:0] c);
    bq = {bq, c, 8'h02, 8'h00, 8'h00, 8'h04};
  endtask
  // ==========
  // result monitor
  always @(posedge clk) begin
    if (host_rd && full) begin
      `CHK(bq.size() != 0, 1'b1)
      tb8 = bq.pop_front();
      `CHK(rdata, tb8)
    end
    if (mstart) begin
      tmv = mq.pop_front();
      `CHK(mv, tmv)
    end
    if (ustart)
      upl_cnt++;
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    summarize();
  end
  // ==========
  // scenarios
  initial begin
    logic [31:0] r;
    logic e;
    logic [1:0] a;
    logic [7:0] c;
    logic [7:0] b[$];
    logic [15:0] w[6];
    {resetn, psel, penable, pwrite, pkt, paddr, pwdata, prom} = '0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    prom <= {rnd(), rnd(), rnd()};
    @(posedge clk);
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, 8'h18 + 8'(4 * k), 32'h0, r, e);
      `CHK(r, {16'h0000, mdef[k]})
    end
    apb(1'b0, 8'h30, 32'h0, r, e);
    `CHK(r, 32'h0001_0640)
    apb(1'b0, 8'hFC, 32'h0, r, e);
    `CHK(e, 1'b1)
    b = '{8'hEE};
    u_host_bfm.send(b, 1'b0, a);
    b = '{8'h03, 8'h00};
    blk(b, 2'b01);
    bq.push_back(8'h33);
    bq.push_back(8'h06);
    for (int k = 0; k < 6; k++)
      bq.push_back(prom[8 * k +: 8]);
    bq.push_back(8'h08);
    u_host_bfm.recv(2'b01);
    foreach (modes[k]) begin
      b = '{8'h02, 8'h02, {3'b000, modes[k]}, 8'h00};
      blk(b, 2'b01);
      rsp(8'h32);
      u_host_bfm.recv(k[0] ? 2'b10 : 2'b01);
      `CHK(rxm, modes[k])
    end
    b = '{8'h01, 8'h0C};
    for (int k = 0; k < 6; k++) begin
      w[k] = rnd();
      b = {b, w[k][7:0], w[k][15:8]};
    end
    blk(b, 2'b01);
    rsp(8'h31);
    u_host_bfm.recv(2'b01);
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, 8'h18 + 8'(4 * k), 32'h0, r, e);
      `CHK(r, {16'h0000, w[k]})
    end
    for (int k = 4; k < 8; k++) begin
      c = 8'(k);
      apb(1'b1, 8'h00, {31'h0, c[0]}, r, e);
      w[0] = rnd() & 16'hFFFE;
      w[1] = rnd();
      w[2] = rnd();
      b = '{c, 8'h06, w[0][7:0], w[0][15:8], w[1][7:0], w[1][15:8], w[2][7:0], w[2][15:8]};
      mq.push_back('{c < 8'h06, c[0], w[0], w[1], w[2]});
      blk(b, 2'b01);
    end
    apb(1'b1, 8'h00, 32'h1, r, e);
    b = '{8'h04, 8'h06, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    blk(b, 2'b10);
    apb(1'b1, 8'h00, 32'h0, r, e);
    b[2] = 8'h03;
    blk(b, 2'b10);
    b = '{8'h02, 8'h3F};
    repeat (63) b.push_back(8'(rnd()));
    blk(b, 2'b10);
    b = '{8'h08, 8'h08, 8'h00, 8'h10, 8'h00, 8'h20, 8'h40, 8'h06, 8'h00, 8'h00};
    blk(b, 2'b01);
    rsp(8'h38);
    repeat (4) @(posedge clk);
    pkt <= 1'b1;
    @(posedge clk);
    pkt <= 1'b0;
    u_host_bfm.recv(2'b01);
    // receive request with a two-tick timeout and no packet
    b = '{8'h08, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
    blk(b, 2'b01);
    repeat (40) @(posedge clk);
    apb(1'b0, 8'h04, 32'h0, r, e);
    `CHK(r[11:0], 12'h210)
    apb(1'b1, 8'h04, 32'h200, r, e);
    apb(1'b0, 8'h04, 32'h0, r, e);
    `CHK(r[11:0], 12'h010)
    // packet noise while nothing pends must not raise a response
    repeat (8) begin
      c = 8'(rnd());
      pkt <= c[0];
      @(posedge clk);
    end
    pkt <= 1'b0;
    `CHK(full, 1'b0)
    repeat (4) @(posedge clk);
    `CHK(upl_cnt, 1)
    `CHK(bq.size(), 0)
    summarize();
  end
endmodule
`default_nettype wire
